// ### hw/sfcd_top.v
// serial flash command decoder with operation status and apb access
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "sfcd_map.vh"
module sfcd_top (
    input wire MCLK_I,
    input wire RST_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [7:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    output reg [31:0] PRDATA_O,
    output reg PREADY_O,
    output reg PSLVERR_O,
    input wire SPI_CS_N_I,
    input wire SPI_SCK_I,
    input wire SPI_SI_I,
    output reg SPI_SO_O,
    output reg SPI_SO_OE_O,
    output reg CMD_STB_O,
    output reg [7:0] CMD_CODE_O,
    output reg [3:0] CMD_CLASS_O,
    output reg CMD_ADDR4_O,
    output reg CMD_REJ_O,
    output reg BUSY_O
);

localparam OP_IDLE = 2'h0;
localparam OP_RUN = 2'h1;
localparam OP_FAIL = 2'h2;
localparam K_PROG = 2'h0;
localparam K_ERASE = 2'h1;
localparam K_REG = 2'h2;

////////////////////////////////////////////////////////////////////////////
// opcode decode: {fixed long address, class}
function [4:0] sfcd_decode;
    input [7:0] c;
    begin
        case (c)
            `SFCD_OP_FAST_RD_LA: sfcd_decode = {1'b1, `SFCD_CL_FAST_RD};
            `SFCD_OP_DDR_FAST_RD: sfcd_decode = {1'b0, `SFCD_CL_DDR_FAST_RD};
            `SFCD_OP_DDR_FAST_RD_LA: sfcd_decode = {1'b1, `SFCD_CL_DDR_FAST_RD};
            `SFCD_OP_DUAL_OUT_RD: sfcd_decode = {1'b0, `SFCD_CL_DUAL_OUT_RD};
            `SFCD_OP_DUAL_OUT_RD_LA: sfcd_decode = {1'b1, `SFCD_CL_DUAL_OUT_RD};
            `SFCD_OP_QUAD_OUT_RD: sfcd_decode = {1'b0, `SFCD_CL_QUAD_OUT_RD};
            `SFCD_OP_QUAD_OUT_RD_LA: sfcd_decode = {1'b1, `SFCD_CL_QUAD_OUT_RD};
            `SFCD_OP_DUAL_IO_RD: sfcd_decode = {1'b0, `SFCD_CL_DUAL_IO_RD};
            `SFCD_OP_DUAL_IO_RD_LA: sfcd_decode = {1'b1, `SFCD_CL_DUAL_IO_RD};
            `SFCD_OP_DDR_DUAL_IO_RD: sfcd_decode = {1'b0, `SFCD_CL_DDR_DUAL_IO_RD};
            `SFCD_OP_DDR_DUAL_IO_RD_LA: sfcd_decode = {1'b1, `SFCD_CL_DDR_DUAL_IO_RD};
            `SFCD_OP_QUAD_IO_RD: sfcd_decode = {1'b0, `SFCD_CL_QUAD_IO_RD};
            `SFCD_OP_QUAD_IO_RD_LA: sfcd_decode = {1'b1, `SFCD_CL_QUAD_IO_RD};
            `SFCD_OP_DDR_QUAD_IO_RD: sfcd_decode = {1'b0, `SFCD_CL_DDR_QUAD_IO_RD};
            `SFCD_OP_DDR_QUAD_IO_RD_LA: sfcd_decode = {1'b1, `SFCD_CL_DDR_QUAD_IO_RD};
            `SFCD_OP_PAGE_PROG: sfcd_decode = {1'b0, `SFCD_CL_PAGE_PROG};
            `SFCD_OP_PAGE_PROG_LA: sfcd_decode = {1'b1, `SFCD_CL_PAGE_PROG};
            `SFCD_OP_QUAD_PROG: sfcd_decode = {1'b0, `SFCD_CL_QUAD_PROG};
            `SFCD_OP_QUAD_PROG_ALT: sfcd_decode = {1'b0, `SFCD_CL_QUAD_PROG};
            `SFCD_OP_QUAD_PROG_LA: sfcd_decode = {1'b1, `SFCD_CL_QUAD_PROG};
            `SFCD_OP_SMALL_ERASE: sfcd_decode = {1'b0, `SFCD_CL_SMALL_ERASE};
            `SFCD_OP_SMALL_ERASE_LA: sfcd_decode = {1'b1, `SFCD_CL_SMALL_ERASE};
            `SFCD_OP_SECT_ERASE: sfcd_decode = {1'b0, `SFCD_CL_SECT_ERASE};
            `SFCD_OP_SECT_ERASE_LA: sfcd_decode = {1'b1, `SFCD_CL_SECT_ERASE};
            `SFCD_OP_RSVD_MULTI_IO: sfcd_decode = {1'b0, `SFCD_CL_RESERVED};
            `SFCD_OP_RSVD_18: sfcd_decode = {1'b0, `SFCD_CL_RESERVED};
            `SFCD_OP_RSVD_E5: sfcd_decode = {1'b0, `SFCD_CL_RESERVED};
            `SFCD_OP_RSVD_E6: sfcd_decode = {1'b0, `SFCD_CL_RESERVED};
            default: sfcd_decode = {1'b0, `SFCD_CL_OTHER};
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// pin synchronisers
reg [2:0] cs_s_q;
reg [2:0] sck_s_q;
reg [1:0] si_s_q;

always @(posedge MCLK_I) begin
    if (RST_I) begin
        cs_s_q <= 3'h7;
        sck_s_q <= 3'h0;
        si_s_q <= 2'h0;
    end else begin
        cs_s_q <= {cs_s_q[1:0], SPI_CS_N_I};
        sck_s_q <= {sck_s_q[1:0], SPI_SCK_I};
        si_s_q <= {si_s_q[0], SPI_SI_I};
    end
end

wire cs_low = ~cs_s_q[1];
wire cs_fall = ~cs_s_q[1] & cs_s_q[2];
wire cs_rise = cs_s_q[1] & ~cs_s_q[2];
wire sck_rise = cs_low & sck_s_q[1] & ~sck_s_q[2];
wire sck_fall = cs_low & ~sck_s_q[1] & sck_s_q[2];
wire si_bit = si_s_q[1];

////////////////////////////////////////////////////////////////////////////
// state registers
reg [4:0] bit_cnt_q;
reg [7:0] shift_q;
reg [7:0] opc_q;
reg opc_ok_q;
reg opc_acc_q;
reg [7:0] bank_new_q;
reg bank_ok_q;
reg [7:0] bank_q;
reg [1:0] op_st_q;
reg [1:0] op_kind_q;
reg [15:0] op_cnt_q;
reg busy_flag_q;
reg write_enable_latch_q;
reg perr_q;
reg eerr_q;
reg so_mode_q;
reg so_sel2_q;
reg [2:0] so_idx_q;
reg [1:0] ctrl_q;
reg [15:0] optime_q;

wire [7:0] opc_d = {shift_q[6:0], si_bit};
wire [4:0] dec_d = sfcd_decode(opc_d);
wire ext_addr = bank_q[`SFCD_BANK_EXT];
wire fail_st = (op_st_q == OP_FAIL);
wire [3:0] dec_cl = dec_d[3:0];
wire is_status_rd = (opc_d == `SFCD_OP_STATUS1_READ) |
    (opc_d == `SFCD_OP_STATUS2_READ);
wire fail_ok = is_status_rd | (opc_d == `SFCD_OP_CLEAR_STATUS) |
    (opc_d == `SFCD_OP_WRITE_DISABLE) | (opc_d == `SFCD_OP_SOFT_RESET);
wire run_ok = is_status_rd | (opc_d == `SFCD_OP_SOFT_RESET);
// reserved codes are never acted on
wire acc_d = (dec_cl != `SFCD_CL_RESERVED) &
    (fail_st ? fail_ok : (op_st_q == OP_RUN) ? run_ok : 1'b1);
wire is_prog = (dec_cl == `SFCD_CL_PAGE_PROG) |
    (dec_cl == `SFCD_CL_QUAD_PROG);
wire is_erase = (dec_cl == `SFCD_CL_SMALL_ERASE) |
    (dec_cl == `SFCD_CL_SECT_ERASE);
wire [4:0] opc_dec = sfcd_decode(opc_q);
wire [3:0] opc_cl = opc_dec[3:0];
wire exe = cs_rise & opc_ok_q & opc_acc_q;

wire [7:0] status1 = {1'b0, perr_q, eerr_q, 3'h0,
    write_enable_latch_q, busy_flag_q};

////////////////////////////////////////////////////////////////////////////
// opcode capture and command report
always @(posedge MCLK_I) begin
    if (RST_I) begin
        bit_cnt_q <= 5'h00;
        shift_q <= 8'h00;
        opc_q <= 8'h00;
        opc_ok_q <= 1'b0;
        opc_acc_q <= 1'b0;
        bank_new_q <= 8'h00;
        bank_ok_q <= 1'b0;
        CMD_STB_O <= 1'b0;
        CMD_CODE_O <= 8'h00;
        CMD_CLASS_O <= 4'h0;
        CMD_ADDR4_O <= 1'b0;
        CMD_REJ_O <= 1'b0;
    end else begin
        CMD_STB_O <= 1'b0;
        if (cs_fall) begin
            bit_cnt_q <= 5'h00;
            opc_ok_q <= 1'b0;
            bank_ok_q <= 1'b0;
        end else if (sck_rise) begin
            shift_q <= opc_d;
            if (bit_cnt_q != 5'h10) begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end
            if (bit_cnt_q == 5'h07) begin
                opc_q <= opc_d;
                opc_ok_q <= 1'b1;
                opc_acc_q <= acc_d;
                CMD_STB_O <= 1'b1;
                CMD_CODE_O <= opc_d;
                CMD_CLASS_O <= dec_cl;
                CMD_ADDR4_O <= dec_d[4] | ext_addr;
                CMD_REJ_O <= ~acc_d;
            end
            if (bit_cnt_q == 5'h0f && opc_q == `SFCD_OP_BANK_WRITE) begin
                bank_new_q <= opc_d;
                bank_ok_q <= 1'b1;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// embedded operation sequencer and status flags
always @(posedge MCLK_I) begin
    if (RST_I) begin
        op_st_q <= OP_IDLE;
        op_kind_q <= K_PROG;
        op_cnt_q <= 16'h0000;
        busy_flag_q <= 1'b0;
        write_enable_latch_q <= 1'b0;
        perr_q <= 1'b0;
        eerr_q <= 1'b0;
        bank_q <= `SFCD_BANK_RST;
        BUSY_O <= 1'b0;
    end else begin
        BUSY_O <= busy_flag_q;
        if (exe) begin
            case (opc_q)
                `SFCD_OP_WRITE_ENABLE: begin
                    write_enable_latch_q <= 1'b1;
                end
                `SFCD_OP_WRITE_DISABLE: begin
                    write_enable_latch_q <= 1'b0;
                end
                `SFCD_OP_CLEAR_STATUS: begin
                    busy_flag_q <= 1'b0;
                    perr_q <= 1'b0;
                    eerr_q <= 1'b0;
                    op_st_q <= OP_IDLE;
                end
                `SFCD_OP_SOFT_RESET: begin
                    busy_flag_q <= 1'b0;
                    perr_q <= 1'b0;
                    eerr_q <= 1'b0;
                    write_enable_latch_q <= 1'b0;
                    op_st_q <= OP_IDLE;
                end
                `SFCD_OP_BANK_WRITE: begin
                    if (bank_ok_q) begin
                        bank_q <= bank_new_q;
                    end
                end
                default: begin
                    // program, erase and register write need the latch
                    if (write_enable_latch_q &&
                        (opc_cl == `SFCD_CL_PAGE_PROG ||
                        opc_cl == `SFCD_CL_QUAD_PROG ||
                        opc_cl == `SFCD_CL_SMALL_ERASE ||
                        opc_cl == `SFCD_CL_SECT_ERASE ||
                        opc_q == `SFCD_OP_WRITE_REG)) begin
                        op_st_q <= OP_RUN;
                        busy_flag_q <= 1'b1;
                        op_cnt_q <= optime_q;
                        if (opc_q == `SFCD_OP_WRITE_REG) begin
                            op_kind_q <= K_REG;
                        end else if (opc_cl == `SFCD_CL_SMALL_ERASE ||
                            opc_cl == `SFCD_CL_SECT_ERASE) begin
                            op_kind_q <= K_ERASE;
                        end else begin
                            op_kind_q <= K_PROG;
                        end
                    end
                end
            endcase
        end else if (op_st_q == OP_RUN) begin
            if (op_cnt_q != 16'h0000) begin
                op_cnt_q <= op_cnt_q - 16'h0001;
            end else if (op_kind_q == K_PROG && ctrl_q[`SFCD_CTRL_PFAIL]) begin
                perr_q <= 1'b1;
                op_st_q <= OP_FAIL;
            end else if (op_kind_q == K_ERASE &&
                ctrl_q[`SFCD_CTRL_EFAIL]) begin
                eerr_q <= 1'b1;
                op_st_q <= OP_FAIL;
            end else begin
                // erase and program of register bits end together
                busy_flag_q <= 1'b0;
                write_enable_latch_q <= 1'b0;
                op_st_q <= OP_IDLE;
            end
        end else if (op_st_q == OP_FAIL) begin
            busy_flag_q <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// status register output on falling clock edges
always @(posedge MCLK_I) begin
    if (RST_I) begin
        so_mode_q <= 1'b0;
        so_sel2_q <= 1'b0;
        so_idx_q <= 3'h7;
        SPI_SO_O <= 1'b0;
        SPI_SO_OE_O <= 1'b0;
    end else begin
        if (cs_rise || cs_fall) begin
            so_mode_q <= 1'b0;
            SPI_SO_OE_O <= 1'b0;
        end else if (sck_rise && bit_cnt_q == 5'h07) begin
            so_mode_q <= is_status_rd;
            so_sel2_q <= (opc_d == `SFCD_OP_STATUS2_READ);
            so_idx_q <= 3'h7;
        end else if (sck_fall && so_mode_q) begin
            SPI_SO_OE_O <= 1'b1;
            SPI_SO_O <= so_sel2_q ? 1'b0 : status1[so_idx_q];
            so_idx_q <= so_idx_q - 3'h1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// apb slave, one wait state per access
wire acc_ph = PSEL_I & PENABLE_I;
wire wr_fire = acc_ph & PREADY_O & PWRITE_I;
reg [31:0] rd_mux;
reg hit;

always @* begin
    rd_mux = 32'h00000000;
    hit = 1'b1;
    case (PADDR_I)
        `SFCD_REG_CTRL: rd_mux = {30'h0, ctrl_q};
        `SFCD_REG_OPTIME: rd_mux = {16'h0, optime_q};
        `SFCD_REG_STATUS: rd_mux = {23'h0, fail_st, status1};
        `SFCD_REG_LASTCMD: rd_mux = {14'h0, CMD_REJ_O, CMD_ADDR4_O,
            4'h0, CMD_CLASS_O, CMD_CODE_O};
        `SFCD_REG_BANK: rd_mux = {24'h0, bank_q};
        default: hit = 1'b0;
    endcase
end

always @(posedge MCLK_I) begin
    if (RST_I) begin
        PREADY_O <= 1'b0;
        PRDATA_O <= 32'h00000000;
        PSLVERR_O <= 1'b0;
        ctrl_q <= `SFCD_CTRL_RST;
        optime_q <= `SFCD_OPTIME_RST;
    end else begin
        PREADY_O <= acc_ph & ~PREADY_O;
        if (acc_ph && !PREADY_O) begin
            PRDATA_O <= PWRITE_I ? 32'h00000000 : rd_mux;
            PSLVERR_O <= ~hit;
        end else begin
            PSLVERR_O <= 1'b0;
        end
        if (wr_fire && PADDR_I == `SFCD_REG_CTRL) begin
            ctrl_q <= PWDATA_I[1:0];
        end
        if (wr_fire && PADDR_I == `SFCD_REG_OPTIME) begin
            optime_q <= PWDATA_I[15:0];
        end
    end
end

endmodule
`default_nettype wire

// ### hw/sfcd_map.vh
// opcodes, apb map, field positions and reset values of the decoder
`ifndef SFCD_MAP_VH
`define SFCD_MAP_VH
// read opcodes
`define SFCD_OP_FAST_RD_LA 8'h0c
`define SFCD_OP_DDR_FAST_RD 8'h0d
`define SFCD_OP_DDR_FAST_RD_LA 8'h0e
`define SFCD_OP_DUAL_OUT_RD 8'h3b
`define SFCD_OP_DUAL_OUT_RD_LA 8'h3c
`define SFCD_OP_QUAD_OUT_RD 8'h6b
`define SFCD_OP_QUAD_OUT_RD_LA 8'h6c
`define SFCD_OP_DUAL_IO_RD 8'hbb
`define SFCD_OP_DUAL_IO_RD_LA 8'hbc
`define SFCD_OP_DDR_DUAL_IO_RD 8'hbd
`define SFCD_OP_DDR_DUAL_IO_RD_LA 8'hbe
`define SFCD_OP_QUAD_IO_RD 8'heb
`define SFCD_OP_QUAD_IO_RD_LA 8'hec
`define SFCD_OP_DDR_QUAD_IO_RD 8'hed
`define SFCD_OP_DDR_QUAD_IO_RD_LA 8'hee
// program and erase opcodes
`define SFCD_OP_PAGE_PROG 8'h02
`define SFCD_OP_PAGE_PROG_LA 8'h12
`define SFCD_OP_QUAD_PROG 8'h32
`define SFCD_OP_QUAD_PROG_ALT 8'h38
`define SFCD_OP_QUAD_PROG_LA 8'h34
`define SFCD_OP_SMALL_ERASE 8'h20
`define SFCD_OP_SMALL_ERASE_LA 8'h21
`define SFCD_OP_SECT_ERASE 8'hd8
`define SFCD_OP_SECT_ERASE_LA 8'hdc
// reserved opcodes
`define SFCD_OP_RSVD_MULTI_IO 8'ha3
`define SFCD_OP_RSVD_18 8'h18
`define SFCD_OP_RSVD_E5 8'he5
`define SFCD_OP_RSVD_E6 8'he6
// control opcodes
`define SFCD_OP_WRITE_REG 8'h01
`define SFCD_OP_WRITE_DISABLE 8'h04
`define SFCD_OP_STATUS1_READ 8'h05
`define SFCD_OP_STATUS2_READ 8'h07
`define SFCD_OP_WRITE_ENABLE 8'h06
`define SFCD_OP_CLEAR_STATUS 8'h30
`define SFCD_OP_BANK_WRITE 8'h17
`define SFCD_OP_SOFT_RESET 8'hf0
// command classes
`define SFCD_CL_OTHER 4'h0
`define SFCD_CL_FAST_RD 4'h1
`define SFCD_CL_DDR_FAST_RD 4'h2
`define SFCD_CL_DUAL_OUT_RD 4'h3
`define SFCD_CL_QUAD_OUT_RD 4'h4
`define SFCD_CL_DUAL_IO_RD 4'h5
`define SFCD_CL_DDR_DUAL_IO_RD 4'h6
`define SFCD_CL_QUAD_IO_RD 4'h7
`define SFCD_CL_DDR_QUAD_IO_RD 4'h8
`define SFCD_CL_PAGE_PROG 4'h9
`define SFCD_CL_QUAD_PROG 4'ha
`define SFCD_CL_SMALL_ERASE 4'hb
`define SFCD_CL_SECT_ERASE 4'hc
`define SFCD_CL_RESERVED 4'hd
// apb byte offsets
`define SFCD_REG_CTRL 8'h00
`define SFCD_REG_OPTIME 8'h04
`define SFCD_REG_STATUS 8'h08
`define SFCD_REG_LASTCMD 8'h0c
`define SFCD_REG_BANK 8'h10
// field positions
`define SFCD_CTRL_PFAIL 0
`define SFCD_CTRL_EFAIL 1
`define SFCD_ST1_BUSY 0
`define SFCD_ST1_WEL 1
`define SFCD_ST1_EERR 5
`define SFCD_ST1_PERR 6
`define SFCD_BANK_EXT 7
// reset values
`define SFCD_CTRL_RST 2'h0
`define SFCD_OPTIME_RST 16'h0040
`define SFCD_BANK_RST 8'h00
`endif

// ### bench/sfcd_checker.sv
// port assertions for the flash command decoder
`timescale 1ns/1ns
`default_nettype none
module sfcd_checker (
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic CMD_STB_O,
    input wire logic [7:0] CMD_CODE_O,
    input wire logic [3:0] CMD_CLASS_O,
    input wire logic CMD_ADDR4_O,
    input wire logic CMD_REJ_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    // f marks codes outside the decoded table
    function automatic logic [3:0] cls_of(input logic [7:0] c);
        case (c)
            8'h0c: cls_of = 4'h1;
            8'h0d, 8'h0e: cls_of = 4'h2;
            8'h3b, 8'h3c: cls_of = 4'h3;
            8'h6b, 8'h6c: cls_of = 4'h4;
            8'hbb, 8'hbc: cls_of = 4'h5;
            8'hbd, 8'hbe: cls_of = 4'h6;
            8'heb, 8'hec: cls_of = 4'h7;
            8'hed, 8'hee: cls_of = 4'h8;
            8'h02, 8'h12: cls_of = 4'h9;
            8'h32, 8'h38, 8'h34: cls_of = 4'ha;
            8'h20, 8'h21: cls_of = 4'hb;
            8'hd8, 8'hdc: cls_of = 4'hc;
            8'ha3, 8'h18, 8'he5, 8'he6: cls_of = 4'hd;
            default: cls_of = 4'hf;
        endcase
    endfunction
    sequence s_setup;
        PSEL_I && !PENABLE_I;
    endsequence
    sequence s_answer;
        !PREADY_O ##1 PREADY_O ##1 !PREADY_O;
    endsequence
    a_apb_wait: assert property (s_setup |=> s_answer)
        else $error("apb answer not after one wait state");
    a_err_map: assert property (PREADY_O |->
        PSLVERR_O == !(PADDR_I inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}))
        else $error("apb error flag does not match address map");
    a_err_rdata: assert property (PSLVERR_O |-> PREADY_O && PRDATA_O == 0)
        else $error("apb error without ready or with data");
    a_stb_pulse: assert property (CMD_STB_O |=> !CMD_STB_O)
        else $error("command strobe longer than one cycle");
    a_code_holds: assert property (CMD_STB_O |=> $stable(CMD_CODE_O) [*8])
        else $error("opcode output changed too soon");
    a_class_map: assert property (CMD_STB_O && cls_of(CMD_CODE_O) != 4'hf
        |-> CMD_CLASS_O == cls_of(CMD_CODE_O))
        else $error("command class wrong for opcode");
    a_long_fixed: assert property (CMD_STB_O && CMD_CODE_O inside {8'h0c,
        8'h0e, 8'h3c, 8'h6c, 8'hbc, 8'hbe, 8'hec, 8'hee, 8'h12, 8'h34, 8'h21,
        8'hdc} |-> CMD_ADDR4_O)
        else $error("fixed long opcode without 4-byte address");
    a_reserved_rej: assert property (CMD_STB_O && CMD_CODE_O inside {8'ha3,
        8'h18, 8'he5, 8'he6} |-> CMD_REJ_O && CMD_CLASS_O == 4'hd)
        else $error("reserved opcode acted on");
endmodule
bind sfcd_top sfcd_checker chk_i (.MCLK_I(MCLK_I), .RST_I(RST_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PADDR_I(PADDR_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .CMD_STB_O(CMD_STB_O), .CMD_CODE_O(CMD_CODE_O),
    .CMD_CLASS_O(CMD_CLASS_O), .CMD_ADDR4_O(CMD_ADDR4_O),
    .CMD_REJ_O(CMD_REJ_O));
`default_nettype wire

// ### bench/sfcd_host.sv
// host spi controller model sending opcode frames
`timescale 1ns/1ns
`default_nettype none
module sfcd_host (
    input wire logic so_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o
);
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b1;
    end
    // n bits msb first; sck stands low between frames
    task automatic xfer(input logic [15:0] d, input int n,
        output logic [7:0] rx);
        rx = 8'h00;
        #13 cs_n_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            si_o = d[15 - i];
            #160 sck_o = 1'b1;
            rx = {rx[6:0], so_i};
            #160 sck_o = 1'b0;
        end
        #160 cs_n_o = 1'b1;
        si_o = ~si_o;
        #200;
    endtask
endmodule
`default_nettype wire

// ### bench/tb_serial_flash_command_decoder.sv
// self-checking bench for the flash command decoder
`timescale 1ns/1ns
`default_nettype none
`include "sfcd_map.vh"
module tb_serial_flash_command_decoder;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, cs_n, sck, si, so, so_oe, stb, a4, rej, busy, e;
    logic [7:0] code, rx;
    logic [3:0] cls;
    logic [13:0] cap, ex;
    int err_count = 0, checks_done = 0, stb_n = 0, oe_n = 0;
    // opcode, class, then {addr4, refused}; no write enable given
    logic [15:0] rows [0:27] = '{16'h0c12, 16'h0d20, 16'h0e22, 16'h3b30,
        16'h3c32, 16'h6b40, 16'h6c42, 16'hbb50, 16'hbc52, 16'hbd60,
        16'hbe62, 16'heb70, 16'hec72, 16'hed80, 16'hee82, 16'h0290,
        16'h1292, 16'h32a0, 16'h38a0, 16'h34a2, 16'h20b0, 16'h21b2,
        16'hd8c0, 16'hdcc2, 16'ha3d1, 16'h18d1, 16'he5d1, 16'he6d1};
    always #20 clk = ~clk;
    sfcd_top uut (.MCLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .SPI_CS_N_I(cs_n),
        .SPI_SCK_I(sck), .SPI_SI_I(si), .SPI_SO_O(so), .SPI_SO_OE_O(so_oe),
        .CMD_STB_O(stb), .CMD_CODE_O(code), .CMD_CLASS_O(cls),
        .CMD_ADDR4_O(a4), .CMD_REJ_O(rej), .BUSY_O(busy));
    sfcd_host host (.so_i(so), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));
    always @(posedge clk) begin
        if (stb === 1'b1) begin
            cap <= {code, cls, a4, rej};
            stb_n <= stb_n + 1;
        end
        if (so_oe === 1'b1) begin
            oe_n <= oe_n + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exv, got);
        checks_done++;
        if (got !== exv) begin
            $display("wrong value %s expected %h seen %h", nm, exv, got);
            err_count++;
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (pready !== 1'b1) begin
            err_count++;
            print_verdict;
        end
    endtask
    task automatic cmd(input logic [15:0] d, input int n = 8);
        host.xfer(d, n, rx);
        repeat (4) @(posedge clk);
    endtask
    task automatic st(input string nm, input logic [31:0] mk, exv);
        apb(1'b0, `SFCD_REG_STATUS, 32'h0);
        chk(nm, exv, r & mk);
    endtask
    task automatic idle;
        int i;
        for (i = 0; i < 100; i++) begin
            apb(1'b0, `SFCD_REG_STATUS, 32'h0);
            if (r[0] === 1'b0) break;
        end
        if (i == 100) begin
            err_count++;
            print_verdict;
        end
    endtask
    task automatic fail_op(input logic [7:0] op, input logic [31:0] ctl, exv);
        apb(1'b1, `SFCD_REG_CTRL, ctl);
        cmd(16'h0600);
        cmd({op, 8'h00});
        repeat (250) @(posedge clk);
        st("fail status", exv, exv);
        apb(1'b1, `SFCD_REG_CTRL, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, `SFCD_REG_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, r);
        apb(1'b0, `SFCD_REG_OPTIME, 32'h0);
        chk("optime reset", 32'h40, r);
        apb(1'b0, `SFCD_REG_BANK, 32'h0);
        chk("bank reset", 32'h0, r);
        st("status reset", 32'hffffffff, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h1, {r[30:0], e});
        apb(1'b1, `SFCD_REG_OPTIME, 32'hc8);
        foreach (rows[k]) begin
            cmd(rows[k]);
            ex = {rows[k][15:4], rows[k][1:0]};
            chk("decode", ex, cap);
            apb(1'b0, `SFCD_REG_LASTCMD, 32'h0);
            r = r & 32'h30fff;
            chk("last", {ex[0], ex[1], 4'h0, ex[5:2], ex[13:6]}, r[17:0]);
            chk("refusal", ex[0], cap[0]);
        end
        chk("strobes", 28, stb_n);
        chk("so idle", 0, oe_n);
        // extended address bit turns variable codes to 4 bytes
        cmd(16'h1780, 16);
        apb(1'b0, `SFCD_REG_BANK, 32'h0);
        chk("bank", 32'h80, r);
        cmd(16'h3b00);
        chk("ext read", {12'h3b3, 2'b10}, cap);
        cmd(16'h1700, 16);
        // program: busy while running, commands other than status read and soft reset refused
        cmd(16'h0600);
        st("wel", 32'h3, 32'h2);
        cmd(16'h0200);
        chk("prog taken", {12'h029, 2'b00}, cap);
        st("busy", 32'h1, 32'h1);
        chk("busy pin", 1'b1, busy);
        cmd(16'h3b00);
        chk("busy refuse", 1'b1, cap[0]);
        idle;
        st("prog done", 32'h163, 32'h0);
        // register write runs as one timed operation
        cmd(16'h0600);
        cmd(16'h0100, 16);
        st("wr busy", 32'h1, 32'h1);
        idle;
        st("wr done", 32'h163, 32'h0);
        // program failure, recovered by clear then disable
        fail_op(8'h02, 32'h1, 32'h141);
        host.xfer(16'h0500, 16, rx);
        chk("so status", 8'h41, rx & 8'h41);
        chk("so enable", 1'b1, oe_n != 0);
        chk("status ok", 1'b0, cap[0]);
        cmd(16'h0600);
        chk("fail refuse", 1'b1, cap[0]);
        cmd(16'h3000);
        st("cleared", 32'h61, 32'h0);
        cmd(16'h0400);
        st("standby", 32'h103, 32'h0);
        // erase failure left by software reset
        fail_op(8'hd8, 32'h2, 32'h121);
        cmd(16'hf000);
        st("soft reset", 32'h163, 32'h0);
        // erase failure left by hardware reset
        fail_op(8'h20, 32'h2, 32'h121);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        st("hard reset", 32'h163, 32'h0);
        print_verdict;
    end
endmodule
`default_nettype wire
